// ### hdl/scb_pkg.sv
// Constants and types of the controller status and control bank.
// Assumes a 100 MHz clock and whole-word AHB-Lite register access.
package scb_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_BUS_STATE = 8'h00;
    localparam logic [7:0] A_TICKS = 8'h04;
    localparam logic [7:0] A_EVENT_COUNT = 8'h08;
    localparam logic [7:0] A_EVENT_CLEAR = 8'h0C;
    localparam logic [7:0] A_UNLOCK_KEY = 8'h10;
    localparam logic [7:0] A_RUN_CMD = 8'h14;
    localparam logic [7:0] A_RUN_STATE = 8'h18;
    localparam logic [7:0] A_RSV_RUNSTOP = 8'h1C;
    localparam logic [1:0] PG_CTRL = 2'h0;
    localparam logic [1:0] PG_LINE0 = 2'h1;
    localparam logic [1:0] PG_LINE1 = 2'h2;
    localparam logic [5:0] O_TX = 6'h00;
    localparam logic [5:0] O_RX = 6'h04;
    localparam logic [5:0] O_ERR = 6'h08;
    localparam logic [5:0] O_EXC = 6'h0C;
    localparam logic [5:0] O_ADR = 6'h10;
    localparam logic [5:0] O_BC = 6'h14;
    localparam logic [5:0] O_NAK = 6'h18;
    localparam logic [5:0] O_BUSY = 6'h1C;
    localparam logic [5:0] O_OVR = 6'h20;
    localparam logic [5:0] O_CLR = 6'h24;

    // ------------------------------------------------------------
    // Field values
    // ------------------------------------------------------------
    localparam int N_LINES = 2;
    localparam int N_EV = 7;
    localparam int EV_TX = 0;
    localparam int EV_RX = 1;
    localparam int EV_ERR = 2;
    localparam int EV_EXC = 3;
    localparam int EV_ADR = 4;
    localparam int EV_BC = 5;
    localparam int EV_OVR = 6;
    localparam logic [15:0] KEY_UNLOCK = 16'h1A2B;
    localparam logic [15:0] CLR_ARM = 16'h0001;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T10_PERIOD_MS = 10;
    localparam int T100_PERIOD_MS = 100;
    localparam int T1S_PERIOD_MS = 1000;
    localparam int T10_HALF_CYCLES = T10_PERIOD_MS * 1000000 / (2 * CLK_PERIOD_NS);
    localparam int DIV_100 = T100_PERIOD_MS / T10_PERIOD_MS;
    localparam int DIV_1S = T1S_PERIOD_MS / T100_PERIOD_MS;
    localparam int PRESC_W = 20;
    localparam int DIV_W = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        bus_config_mismatch = 16'h0001,
        bus_config_match = 16'h0003,
        bus_unpowered = 16'h0004
    } scb_bus_state_type_t;

    typedef enum logic [15:0] {
        cmd_none = 16'h0000,
        cmd_run = 16'h0001,
        cmd_stop = 16'h0002
    } scb_run_stop_command_type_t;

    typedef enum logic [0:0] {
        ctrl_stopped = 1'b0,
        ctrl_running = 1'b1
    } scb_ctrl_state_t;

    typedef struct packed {
        logic [31:0] tx;
        logic [31:0] rx;
        logic [31:0] err;
        logic [15:0] exc;
        logic [15:0] adr;
        logic [15:0] bc;
        logic [15:0] ovr;
    } scb_cnt_state_t;

endpackage

// ### hdl/scb_cnt_if.sv
// Interface between the bank and one serial-line counter set.
// Assumes events and clear are single-cycle, synchronous to the clock.
`timescale 1ns/100ps
interface scb_cnt_if;
    logic [scb_pkg::N_EV-1:0] ev;
    logic clear;
    scb_pkg::scb_cnt_state_t cnt;
    modport ctl (output ev, output clear, input cnt);
    modport ctr (input ev, input clear, output cnt);
endinterface

// ### hdl/scb_ser_counters.sv
// Diagnostic counters of one serial line.
// Assumes one clock, active-low asynchronous reset and a clock enable.
`timescale 1ns/100ps
module scb_ser_counters (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    scb_cnt_if.ctr cif
);
    scb_pkg::scb_cnt_state_t s;
    scb_pkg::scb_cnt_state_t next_s;

    function automatic logic [31:0] bump32(logic [31:0] v, logic en);
        return en ? v + 32'h00000001 : v;
    endfunction

    function automatic logic [15:0] bump16(logic [15:0] v, logic en);
        return en ? v + 16'h0001 : v;
    endfunction

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (cif.clear) begin
            next_s = '0; // RQ18
        end else begin
            next_s.tx = bump32(s.tx, cif.ev[scb_pkg::EV_TX]); // RQ10
            next_s.rx = bump32(s.rx, cif.ev[scb_pkg::EV_RX]); // RQ11
            next_s.err = bump32(s.err, cif.ev[scb_pkg::EV_ERR]); // RQ12
            next_s.exc = bump16(s.exc, cif.ev[scb_pkg::EV_EXC]); // RQ13
            next_s.adr = bump16(s.adr, cif.ev[scb_pkg::EV_ADR]); // RQ14
            next_s.bc = bump16(s.bc, cif.ev[scb_pkg::EV_BC]); // RQ15
            next_s.ovr = bump16(s.ovr, cif.ev[scb_pkg::EV_OVR]); // RQ16 RQ20
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= '0; // RQ18
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    assign cif.cnt = s;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cnt_clear;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_ce && cif.clear |=> s == '0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counters not cleared"); // RQ19

    property p_tx_inc;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_ce && !cif.clear && cif.ev[scb_pkg::EV_TX] |=> s.tx == $past(s.tx) + 32'h00000001;
    endproperty
    a_tx_inc: assert property (p_tx_inc) else $error("tx count missed"); // RQ10

    property p_ovr_wrap;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_ce && !cif.clear && cif.ev[scb_pkg::EV_OVR] && s.ovr == 16'hFFFF |=> s.ovr == 16'h0000;
    endproperty
    a_ovr_wrap: assert property (p_ovr_wrap) else $error("overrun count no wrap"); // RQ20

endmodule // scb_ser_counters

// ### hdl/scb_bank.sv
// Controller status and control bank with serial-line diagnostics.
// Assumes an AHB-Lite master, single-cycle event pulses and a 100 MHz clock.
//
// Function
// RQ1 - Expansion bus state reads 1 mismatch, 3 match, 4 unpowered.
// RQ2 - First time-base bit has a full period of 10 ms.
// RQ3 - Second time-base bit has a full period of 100 ms.
// RQ4 - Third time-base bit has a full period of 1 s.
// RQ5 - Time-base bits run in both stopped and running states.
// RQ6 - Event counter clears only on clear word going 0 to 1.
// RQ7 - Run/stop command executes when unlock key goes 0 to 6699.
// RQ8 - Command selects run or stop, effective only on key transition.
// RQ9 - Two serial counter sets; only the first is fed, second reserved.
// RQ10 - 32-bit count of frames transmitted successfully.
// RQ11 - 32-bit count of frames received without error.
// RQ12 - 32-bit count of frames failing checksum or parity.
// RQ13 - Count of exception responses returned as slave.
// RQ14 - Count of messages addressed to this controller.
// RQ15 - Count of broadcast requests received.
// RQ16 - Count of receive character overruns.
// RQ17 - Negative-acknowledge and busy counters are not maintained.
// RQ18 - Serial counters clear on download, reset, clear word, diagnostic request.
// RQ19 - A line's counters clear on its clear word going 0 to 1.
// RQ20 - Counters wrap to zero instead of saturating.
// RQ21 - Clear edges compare against the previous cycle's value.
`timescale 1ns/100ps
module scb_bank #(
    parameter int TICK10_HALF_CYCLES = scb_pkg::T10_HALF_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    input wire logic i_bus_powered,
    input wire logic i_bus_cfg_match,
    input wire logic i_event,
    input wire logic i_tx_ok,
    input wire logic i_rx_ok,
    input wire logic i_rx_err,
    input wire logic i_exc_resp,
    input wire logic i_addr_msg,
    input wire logic i_bcast_req,
    input wire logic i_overrun,
    input wire logic i_diag_clear,
    input wire logic i_download,
    output logic o_running,
    output logic o_tick_10ms,
    output logic o_tick_100ms,
    output logic o_tick_1s
);
    localparam int PW = scb_pkg::PRESC_W;
    localparam int DW = scb_pkg::DIV_W;
    localparam logic [PW-1:0] PRESC_LAST = PW'(TICK10_HALF_CYCLES - 1);
    localparam logic [DW-1:0] DIV100_LAST = DW'(scb_pkg::DIV_100 - 1);
    localparam logic [DW-1:0] DIV1S_LAST = DW'(scb_pkg::DIV_1S - 1);

    if (TICK10_HALF_CYCLES < 1 || TICK10_HALF_CYCLES > 2 ** PW) begin : g_chk
        $error("tick prescale out of range");
    end

    typedef struct packed {
        scb_pkg::scb_bus_state_type_t bus_state;
        logic [PW-1:0] presc;
        logic [DW-1:0] div100;
        logic [DW-1:0] div1s;
        logic t10;
        logic t100;
        logic t1s;
        logic [15:0] ev_cnt;
        logic [15:0] ev_clr;
        logic [15:0] ev_clr_prev;
        logic [15:0] key;
        logic [15:0] key_prev;
        scb_pkg::scb_run_stop_command_type_t cmd;
        scb_pkg::scb_ctrl_state_t run;
        logic [scb_pkg::N_LINES-1:0][15:0] ser_clr;
        logic [scb_pkg::N_LINES-1:0][15:0] ser_clr_prev;
        logic rd_pend;
        logic wr_pend;
        logic [7:0] addr;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
    } scb_bank_state_t;

    scb_bank_state_t s;
    scb_bank_state_t next_s;
    logic [31:0] rd_val;
    logic key_fire;
    logic ev_clr_edge;
    logic [scb_pkg::N_LINES-1:0] line_clr;
    scb_pkg::scb_cnt_state_t line_cnt [scb_pkg::N_LINES];

    // ------------------------------------------------------------
    // Serial counter sets
    // ------------------------------------------------------------
    for (genvar g = 0; g < scb_pkg::N_LINES; g++) begin : g_line
        scb_cnt_if cif ();
        if (g == 0) begin : g_fed
            assign cif.ev = {i_overrun, i_bcast_req, i_addr_msg, i_exc_resp,
                             i_rx_err, i_rx_ok, i_tx_ok};
            assign line_clr[g] = (s.ser_clr[g] == scb_pkg::CLR_ARM && // RQ19
                                  s.ser_clr_prev[g] == scb_pkg::WORD_ZERO) || // RQ21
                                 i_diag_clear || i_download; // RQ18
        end else begin : g_rsv
            assign cif.ev = '0; // RQ9
            assign line_clr[g] = s.ser_clr[g] == scb_pkg::CLR_ARM && // RQ19
                                 s.ser_clr_prev[g] == scb_pkg::WORD_ZERO; // RQ21
        end
        assign cif.clear = line_clr[g];
        assign line_cnt[g] = cif.cnt;
        scb_ser_counters u_cnt (
            .i_mclk(i_mclk),
            .i_nrst(i_nrst),
            .i_ce(i_ce),
            .cif(cif.ctr)
        );
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    function automatic logic [31:0] line_rd(scb_pkg::scb_cnt_state_t c,
                                           logic [15:0] clr, logic [5:0] off);
        logic [31:0] v;
        v = 32'h00000000;
        case (off)
            scb_pkg::O_TX: v = c.tx;
            scb_pkg::O_RX: v = c.rx;
            scb_pkg::O_ERR: v = c.err;
            scb_pkg::O_EXC: v = {16'h0000, c.exc};
            scb_pkg::O_ADR: v = {16'h0000, c.adr};
            scb_pkg::O_BC: v = {16'h0000, c.bc};
            scb_pkg::O_NAK: v = 32'h00000000; // RQ17
            scb_pkg::O_BUSY: v = 32'h00000000; // RQ17
            scb_pkg::O_OVR: v = {16'h0000, c.ovr};
            scb_pkg::O_CLR: v = {16'h0000, clr};
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction

    always_comb begin
        rd_val = 32'h00000000;
        case (s.addr[7:6])
            scb_pkg::PG_CTRL: begin
                case (s.addr)
                    scb_pkg::A_BUS_STATE: rd_val = {16'h0000, s.bus_state};
                    scb_pkg::A_TICKS: rd_val = {29'h0, s.t1s, s.t100, s.t10};
                    scb_pkg::A_EVENT_COUNT: rd_val = {16'h0000, s.ev_cnt};
                    scb_pkg::A_EVENT_CLEAR: rd_val = {16'h0000, s.ev_clr};
                    scb_pkg::A_UNLOCK_KEY: rd_val = {16'h0000, s.key};
                    scb_pkg::A_RUN_CMD: rd_val = {16'h0000, s.cmd};
                    scb_pkg::A_RUN_STATE: rd_val = {31'h0, s.run};
                    default: rd_val = 32'h00000000;
                endcase
            end
            scb_pkg::PG_LINE0: rd_val = line_rd(line_cnt[0], s.ser_clr[0], s.addr[5:0]);
            scb_pkg::PG_LINE1: rd_val = line_rd(line_cnt[1], s.ser_clr[1], s.addr[5:0]);
            default: rd_val = 32'h00000000;
        endcase
    end

    assign key_fire = s.key == scb_pkg::KEY_UNLOCK && s.key_prev == scb_pkg::WORD_ZERO;
    assign ev_clr_edge = s.ev_clr == scb_pkg::CLR_ARM && s.ev_clr_prev == scb_pkg::WORD_ZERO;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Expansion bus health
        if (!i_bus_powered) begin
            next_s.bus_state = scb_pkg::bus_unpowered; // RQ1
        end else if (i_bus_cfg_match) begin
            next_s.bus_state = scb_pkg::bus_config_match; // RQ1
        end else begin
            next_s.bus_state = scb_pkg::bus_config_mismatch; // RQ1
        end
        // Time base, independent of run state
        if (s.presc == PRESC_LAST) begin // RQ5
            next_s.presc = '0;
            next_s.t10 = ~s.t10; // RQ2
            if (s.div100 == DIV100_LAST) begin
                next_s.div100 = '0;
                next_s.t100 = ~s.t100; // RQ3
                if (s.div1s == DIV1S_LAST) begin
                    next_s.div1s = '0;
                    next_s.t1s = ~s.t1s; // RQ4
                end else begin
                    next_s.div1s = s.div1s + 4'h1;
                end
            end else begin
                next_s.div100 = s.div100 + 4'h1;
            end
        end else begin
            next_s.presc = s.presc + PW'(1);
        end
        // Event counter
        if (ev_clr_edge) begin
            next_s.ev_cnt = 16'h0000; // RQ6
        end else if (i_event) begin
            next_s.ev_cnt = s.ev_cnt + 16'h0001; // RQ20
        end
        next_s.ev_clr_prev = s.ev_clr; // RQ21
        next_s.ser_clr_prev = s.ser_clr; // RQ21
        // Keyed run/stop
        next_s.key_prev = s.key;
        if (key_fire) begin // RQ7
            unique case (s.cmd)
                scb_pkg::cmd_run: next_s.run = scb_pkg::ctrl_running; // RQ8
                scb_pkg::cmd_stop: next_s.run = scb_pkg::ctrl_stopped; // RQ8
                default: next_s.run = s.run;
            endcase
        end
        // Bus slave: read data one cycle after address phase
        next_s.hresp = 1'b0;
        if (s.rd_pend) begin
            next_s.hrdata = rd_val;
            next_s.hready = 1'b1;
            next_s.rd_pend = 1'b0;
        end
        if (s.wr_pend) begin
            next_s.wr_pend = 1'b0;
            case (s.addr)
                scb_pkg::A_EVENT_CLEAR: next_s.ev_clr = i_hwdata[15:0];
                scb_pkg::A_UNLOCK_KEY: next_s.key = i_hwdata[15:0];
                scb_pkg::A_RUN_CMD:
                    next_s.cmd = scb_pkg::scb_run_stop_command_type_t'(i_hwdata[15:0]);
                {scb_pkg::PG_LINE0, scb_pkg::O_CLR}: next_s.ser_clr[0] = i_hwdata[15:0];
                {scb_pkg::PG_LINE1, scb_pkg::O_CLR}: next_s.ser_clr[1] = i_hwdata[15:0];
                default: next_s.wr_pend = 1'b0;
            endcase
        end
        if (i_hsel && i_htrans[1] && i_hready) begin
            next_s.addr = i_haddr[7:0];
            if (i_hwrite) begin
                next_s.wr_pend = 1'b1;
            end else begin
                next_s.rd_pend = 1'b1;
                next_s.hready = 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= '0;
            s.hready <= 1'b1;
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    assign o_hreadyout = s.hready;
    assign o_hrdata = s.hrdata;
    assign o_hresp = s.hresp;
    assign o_running = s.run;
    assign o_tick_10ms = s.t10;
    assign o_tick_100ms = s.t100;
    assign o_tick_1s = s.t1s;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [PW:0] h_t10_gap;
    logic h_t10_d;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            h_t10_gap <= '0;
            h_t10_d <= 1'b0;
        end else if (i_ce) begin
            h_t10_d <= o_tick_10ms;
            h_t10_gap <= (o_tick_10ms != h_t10_d) ? (PW + 1)'(1) : h_t10_gap + (PW + 1)'(1);
        end
    end

    property p_t10;
        @(posedge i_mclk) disable iff (!i_nrst)
        $changed(o_tick_10ms) |-> h_t10_gap == (PW + 1)'(TICK10_HALF_CYCLES);
    endproperty
    a_t10: assert property (p_t10) else $error("10 ms bit half period wrong"); // RQ2

    property p_t100;
        @(posedge i_mclk) disable iff (!i_nrst)
        $changed(o_tick_100ms) |-> $changed(o_tick_10ms) && $past(s.div100) == DIV100_LAST;
    endproperty
    a_t100: assert property (p_t100) else $error("100 ms bit off its base"); // RQ3

    property p_t1s;
        @(posedge i_mclk) disable iff (!i_nrst)
        $changed(o_tick_1s) |-> $changed(o_tick_100ms) && $past(s.div1s) == DIV1S_LAST;
    endproperty
    a_t1s: assert property (p_t1s) else $error("1 s bit off its base"); // RQ4

    property p_bus;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_ce && !i_bus_powered |=> s.bus_state == scb_pkg::bus_unpowered;
    endproperty
    a_bus: assert property (p_bus) else $error("unpowered bus not reported"); // RQ1

    property p_evclr;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_ce && s.ev_clr_prev == scb_pkg::CLR_ARM && !i_event |=> s.ev_cnt == $past(s.ev_cnt);
    endproperty
    a_evclr: assert property (p_evclr) else $error("held clear word cleared again"); // RQ21

    property p_evedge;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_ce && ev_clr_edge |=> s.ev_cnt == 16'h0000;
    endproperty
    a_evedge: assert property (p_evedge) else $error("event counter not cleared"); // RQ6

    property p_key;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_ce && key_fire && s.cmd == scb_pkg::cmd_run |=> o_running;
    endproperty
    a_key: assert property (p_key) else $error("run command not executed"); // RQ7

    property p_nokey;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_ce && !key_fire |=> o_running == $past(o_running);
    endproperty
    a_nokey: assert property (p_nokey) else $error("run state moved without key"); // RQ8

    property p_nak;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_ce && s.rd_pend && s.addr[7:6] == scb_pkg::PG_LINE0 &&
        s.addr[5:0] == scb_pkg::O_NAK |=> o_hrdata == 32'h00000000 && o_hreadyout;
    endproperty
    a_nak: assert property (p_nak) else $error("unused counter read not zero"); // RQ17

    property p_rsv;
        @(posedge i_mclk) disable iff (!i_nrst)
        1'b1 |-> line_cnt[1] == '0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved line counted"); // RQ9

    c_run: cover property (@(posedge i_mclk) disable iff (!i_nrst) $rose(o_running));
    c_ser_clr: cover property (@(posedge i_mclk) disable iff (!i_nrst) i_ce && line_clr[0]);
    c_rd: cover property (@(posedge i_mclk) disable iff (!i_nrst) s.rd_pend ##1 o_hreadyout);

endmodule // scb_bank

// ### verification/scb_line_model.sv
// Far-side model: serial master and line, as trains of event pulses.
// Assumes the bench holds kind and count while busy is high.
`timescale 1ns/100ps
module scb_line_model (
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic [2:0] i_kind,
    input wire logic [7:0] i_count,
    output logic [6:0] o_ev,
    output logic o_busy
);
    logic [7:0] left = 8'h00;
    always @(posedge i_mclk) begin
        if (i_go) begin
            left <= i_count;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    assign o_ev = (left != 8'h00) ? (7'h01 << i_kind) : 7'h00;
    assign o_busy = (left != 8'h00);
endmodule // scb_line_model

// ### verification/scb_bank_tb.sv
// Self-checking bench of the status and control bank.
// Assumes the line model is compiled first; AHB-Lite master in tasks.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module scb_bank_tb;
    localparam logic [7:0] TX0 = {scb_pkg::PG_LINE0, scb_pkg::O_TX};
    localparam logic [7:0] RX0 = {scb_pkg::PG_LINE0, scb_pkg::O_RX};
    localparam logic [7:0] CLR0 = {scb_pkg::PG_LINE0, scb_pkg::O_CLR};
    logic i_mclk = 1'b0, i_nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic pwr = 1'b1, match = 1'b1, hreadyout, hresp, running, busy;
    logic [1:0] htrans = 2'h0;
    logic [2:0] misc = 3'h0, kind = 3'h0, ticks;
    logic [7:0] cnt = 8'h00;
    logic [6:0] ev;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    int mismatches = 0, samples_checked = 0;
    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    scb_bank #(.TICK10_HALF_CYCLES(5)) uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(1'b1),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
        .o_hrdata(hrdata), .o_hresp(hresp), .i_bus_powered(pwr), .i_bus_cfg_match(match),
        .i_event(misc[0]), .i_tx_ok(ev[0]), .i_rx_ok(ev[1]), .i_rx_err(ev[2]),
        .i_exc_resp(ev[3]), .i_addr_msg(ev[4]), .i_bcast_req(ev[5]), .i_overrun(ev[6]),
        .i_diag_clear(misc[1]), .i_download(misc[2]), .o_running(running),
        .o_tick_10ms(ticks[0]), .o_tick_100ms(ticks[1]), .o_tick_1s(ticks[2]));
    scb_line_model far (.i_mclk(i_mclk), .i_go(go), .i_kind(kind), .i_count(cnt),
        .o_ev(ev), .o_busy(busy));
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge i_mclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do begin
            @(negedge i_mclk);
            rdy = hreadyout;
            @(posedge i_mclk);
        end while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(negedge i_mclk);
            rdy = hreadyout;
            rdat = hrdata;
            @(posedge i_mclk);
        end while (rdy !== 1'b1);
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %0h", a), e, rdat)
    endtask
    task automatic fire(input int k, input int c);
        @(posedge i_mclk);
        kind <= 3'(k);
        cnt <= 8'(c);
        go <= 1'b1;
        @(posedge i_mclk);
        go <= 1'b0;
        do @(negedge i_mclk); while (busy);
    endtask
    task automatic strobe(input int k);
        @(posedge i_mclk);
        misc <= 3'(1 << k);
        @(posedge i_mclk);
        misc <= 3'h0;
    endtask
    task automatic period(input int w, input int e);
        int c;
        c = 0;
        do @(negedge i_mclk); while (ticks[w]);
        do @(negedge i_mclk); while (!ticks[w]);
        do begin @(negedge i_mclk); c++; end while (ticks[w]);
        do begin @(negedge i_mclk); c++; end while (!ticks[w]);
        `CHK("tick period", e, c)
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_bus_state;
        pwr <= 1'b0;
        rd(scb_pkg::A_BUS_STATE, 32'h4);
        pwr <= 1'b1;
        match <= 1'b0;
        rd(scb_pkg::A_BUS_STATE, 32'h1);
        match <= 1'b1;
        rd(scb_pkg::A_BUS_STATE, 32'h3);
    endtask
    task automatic t_event;
        repeat (3) strobe(0);
        rd(scb_pkg::A_EVENT_COUNT, 32'h3);
        ahb(1'b1, scb_pkg::A_EVENT_CLEAR, 32'h1);
        strobe(0);
        rd(scb_pkg::A_EVENT_COUNT, 32'h1);
        ahb(1'b1, scb_pkg::A_EVENT_CLEAR, 32'h1);
        rd(scb_pkg::A_EVENT_COUNT, 32'h1);
    endtask
    task automatic t_counters;
        logic [5:0] offs [7] = '{scb_pkg::O_TX, scb_pkg::O_RX, scb_pkg::O_ERR,
            scb_pkg::O_EXC, scb_pkg::O_ADR, scb_pkg::O_BC, scb_pkg::O_OVR};
        for (int k = 0; k < 7; k++) fire(k, k + 2);
        for (int k = 0; k < 7; k++) begin
            rd({scb_pkg::PG_LINE0, offs[k]}, 32'(k + 2));
            rd({scb_pkg::PG_LINE1, offs[k]}, 32'h0);
        end
        rd({scb_pkg::PG_LINE0, scb_pkg::O_NAK}, 32'h0);
        rd({scb_pkg::PG_LINE0, scb_pkg::O_BUSY}, 32'h0);
    endtask
    task automatic t_clears;
        ahb(1'b1, CLR0, 32'h1);
        rd(TX0, 32'h0);
        fire(0, 3);
        ahb(1'b1, CLR0, 32'h1);
        rd(TX0, 32'h3);
        ahb(1'b1, CLR0, 32'h0);
        ahb(1'b1, CLR0, 32'h1);
        rd(TX0, 32'h0);
        for (int k = 1; k < 3; k++) begin
            fire(1, 2);
            strobe(k);
            rd(RX0, 32'h0);
        end
        fire(1, 2);
        @(posedge i_mclk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rd(RX0, 32'h0);
    endtask
    task automatic t_ticks;
        period(0, 10);
        period(1, 100);
        period(2, 1000);
    endtask
    task automatic t_run;
        ahb(1'b1, scb_pkg::A_RUN_CMD, {16'h0, scb_pkg::cmd_run});
        ahb(1'b1, scb_pkg::A_UNLOCK_KEY, {16'h0, scb_pkg::KEY_UNLOCK});
        rd(scb_pkg::A_RUN_STATE, 32'h1);
        t_ticks;
        ahb(1'b1, scb_pkg::A_RUN_CMD, {16'h0, scb_pkg::cmd_stop});
        rd(scb_pkg::A_RUN_STATE, 32'h1);
        ahb(1'b1, scb_pkg::A_UNLOCK_KEY, {16'h0, scb_pkg::KEY_UNLOCK});
        rd(scb_pkg::A_RUN_STATE, 32'h1);
        ahb(1'b1, scb_pkg::A_UNLOCK_KEY, 32'h0);
        ahb(1'b1, scb_pkg::A_UNLOCK_KEY, {16'h0, scb_pkg::KEY_UNLOCK});
        rd(scb_pkg::A_RUN_STATE, 32'h0);
        `CHK("running", 1'b0, running)
    endtask
    task automatic close_out;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_mclk);
        mismatches++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge i_mclk);
        i_nrst <= 1'b1;
        t_bus_state;
        t_event;
        t_counters;
        t_clears;
        t_ticks;
        t_run;
        close_out;
    end
endmodule // scb_bank_tb
